// file: smc_pkg.sv
// ============================================================
// shared constants for the output mute and reference block
package smc_pkg;
	localparam int NCH = 4;
	localparam int CD_W = 12;
	localparam int SD_W = 20;
	localparam int DLY_W = 8;
	localparam int NAUX = 2;
	localparam int NCMOS = 4;
	localparam int NASYNC = 5;
	localparam int SYNC_DEPTH = 3;
	localparam int PULSE_W = 4;
	// source clock is the loop post-divider output
	localparam int SRC_HZ = 25_000_000;
	localparam int SR_MAX_HZ = 25_000_000;
	localparam logic [7:0] REG_REQ_CTRL = 8'h1a;
	localparam logic [7:0] REG_REQ_RESET = 8'h00;
	localparam int REQ_MODE_LSB = 4;
	localparam int REQ_SEL_LSB = 2;
	localparam logic [1:0] REQ_MODE_RESAMPLE = 2'h3;
	localparam logic [PULSE_W-1:0] PULSE_CNT = 4'h4;
	// async input bit positions
	localparam int AS_ALOL = 0;
	localparam int AS_DLOL = 1;
	localparam int AS_PLOL = 2;
	localparam int AS_SYNC = 3;
	localparam int AS_REQ = 4;
	typedef enum logic [1:0] {
		SMC_CMOS_NORMAL,
		SMC_CMOS_INVERT,
		SMC_CMOS_HIZ,
		SMC_CMOS_LOW
	} smc_cmos_mode_t;
	typedef enum logic {
		SMC_PULSE_IDLE,
		SMC_PULSE_BURST
	} smc_pulse_state_t;
endpackage : smc_pkg

// file: smc_output_ctrl.sv
`timescale 1ns/100ps
module smc_output_ctrl (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic regWrEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic analogLossOfLock,
	input wire logic digitalLossOfLock,
	input wire logic phaseLossOfLock,
	input wire logic syncPin,
	input wire logic sysrefReq,
	input wire logic [smc_pkg::NCH*smc_pkg::CD_W-1:0] chDiv,
	input wire logic [smc_pkg::NCH*smc_pkg::SD_W-1:0] srDiv,
	input wire logic [smc_pkg::NCH*smc_pkg::DLY_W-1:0] staticDly,
	input wire logic [smc_pkg::NCH*smc_pkg::DLY_W-1:0] srDly,
	input wire logic [smc_pkg::NCH-1:0] srSelect,
	input wire logic [smc_pkg::NCH-1:0] analogDlyEn,
	input wire logic [smc_pkg::NCH-1:0] pulsedMode,
	input wire logic [smc_pkg::NCH-1:0] syncEn,
	input wire logic [smc_pkg::NCH*2-1:0] driverEn,
	input wire logic [smc_pkg::NCH-1:0] muteEn,
	input wire logic [smc_pkg::NCH-1:0] mute_on_analog_loop_unlock,
	input wire logic [smc_pkg::NCH-1:0] mute_on_digital_loop_unlock,
	input wire logic [smc_pkg::NCH-1:0] mute_on_digital_phase_unlock,
	input wire logic [smc_pkg::NCH-1:0] divider_pin_replica_enable,
	input wire logic [smc_pkg::NAUX-1:0] aux_pin_output_enable,
	input wire logic [smc_pkg::NCMOS*2-1:0] cmosMode,
	output logic [smc_pkg::NCH-1:0] chOut,
	output logic [smc_pkg::NCH-1:0] divPowered,
	output logic [smc_pkg::NAUX-1:0] auxOut,
	output logic [smc_pkg::NAUX-1:0] auxOe,
	output logic [smc_pkg::NCMOS-1:0] cmosOut,
	output logic [smc_pkg::NCMOS-1:0] cmosOe
);
	// returns {output enable, level} for one single-ended pin
	function automatic logic [1:0] cmos_drive(
		input logic [1:0] mode,
		input logic clk
	);
		logic [1:0] res;
		res = 2'h0;
		case (smc_pkg::smc_cmos_mode_t'(mode))
			smc_pkg::SMC_CMOS_NORMAL: res = {1'b1, clk};
			smc_pkg::SMC_CMOS_INVERT: res = {1'b1, ~clk};
			smc_pkg::SMC_CMOS_HIZ: res = 2'h0;
			smc_pkg::SMC_CMOS_LOW: res = 2'h2;
			default: res = 2'h0;
		endcase
		return res;
	endfunction : cmos_drive
	// ============================================================
	// register and input synchronisers
	logic [7:0] reqCtrl_r;
	logic [1:0] reqMode;
	logic [1:0] reqSel;
	logic [smc_pkg::NASYNC-1:0] asyncIn;
	logic [smc_pkg::NASYNC-1:0] filt_r;
	logic reqPrev_r;
	logic reqEvent;
	logic reqPending_r;
	logic reqFire;
	logic [smc_pkg::NCH-1:0] srTick;
	logic [smc_pkg::NCH-1:0] replTap;
	assign reqMode = reqCtrl_r[smc_pkg::REQ_MODE_LSB +: 2];
	assign reqSel = reqCtrl_r[smc_pkg::REQ_SEL_LSB +: 2];
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reqCtrl_r <= smc_pkg::REG_REQ_RESET;
		end else if (regWrEn && regAddr == smc_pkg::REG_REQ_CTRL) begin
			reqCtrl_r <= regWrData;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			regRdData <= 8'h00;
		end else begin
			regRdData <= (regAddr == smc_pkg::REG_REQ_CTRL) ? reqCtrl_r : 8'h00;
		end
	end
	assign asyncIn = {sysrefReq, syncPin, phaseLossOfLock,
		digitalLossOfLock, analogLossOfLock};
	for (genvar a = 0; a < smc_pkg::NASYNC; a++) begin : g_sync
		logic [smc_pkg::SYNC_DEPTH-1:0] s_r;
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				s_r <= '0;
				filt_r[a] <= 1'b0;
			end else begin
				s_r <= {s_r[1:0], asyncIn[a]};
				// a change counts once the last two stages agree
				if (s_r[1] == s_r[2]) begin
					filt_r[a] <= s_r[2];
				end
			end
		end
	end
	// ============================================================
	// reference request, optionally resampled on a divider boundary
	assign reqEvent = filt_r[smc_pkg::AS_REQ] & ~reqPrev_r;
	assign reqFire = (reqMode == smc_pkg::REQ_MODE_RESAMPLE)
		? (reqPending_r | reqEvent) & srTick[reqSel] : reqEvent;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reqPrev_r <= 1'b0;
			reqPending_r <= 1'b0;
		end else begin
			reqPrev_r <= filt_r[smc_pkg::AS_REQ];
			// a firing clears the pending flag, even with a new request in the same cycle
			if (reqEvent && !reqFire) begin
				reqPending_r <= 1'b1;
			end else if (reqFire) begin
				reqPending_r <= 1'b0;
			end
		end
	end
	// ============================================================
	// per-channel divider, delay, pulser and mute
	for (genvar c = 0; c < smc_pkg::NCH; c++) begin : g_ch
		logic [smc_pkg::CD_W-1:0] cdCnt_r;
		logic [smc_pkg::CD_W-1:0] cdLim;
		logic [smc_pkg::SD_W-1:0] srCnt_r;
		logic [smc_pkg::SD_W-1:0] srLim;
		logic [smc_pkg::DLY_W:0] dlyCnt_r;
		logic [smc_pkg::DLY_W:0] dlyLoad;
		logic [smc_pkg::PULSE_W-1:0] pulseCnt_r;
		smc_pkg::smc_pulse_state_t pState_r;
		logic cdTick;
		logic cdOut_r;
		logic srOut_r;
		logic adly_r;
		logic base;
		logic shaped;
		logic gateOpen_r;
		logic muted_r;
		logic muteCond;
		logic powerDown;
		logic syncHold;
		logic startOk;
		logic held;
		assign cdLim = chDiv[c*smc_pkg::CD_W +: smc_pkg::CD_W];
		assign srLim = srDiv[c*smc_pkg::SD_W +: smc_pkg::SD_W];
		assign powerDown = ~|driverEn[c*2 +: 2];
		assign syncHold = filt_r[smc_pkg::AS_SYNC] & syncEn[c];
		// mute conditions from each loop's lock status
		assign muteCond = muteEn[c] & (
			(mute_on_analog_loop_unlock[c] & filt_r[smc_pkg::AS_ALOL])
			| (mute_on_digital_loop_unlock[c] & filt_r[smc_pkg::AS_DLOL])
			| (mute_on_digital_phase_unlock[c]
			& filt_r[smc_pkg::AS_PLOL]));
		// start waits for analog lock when auto-mute covers it
		assign startOk = ~(muteEn[c] & mute_on_analog_loop_unlock[c]
			& filt_r[smc_pkg::AS_ALOL]);
		assign dlyLoad = {1'b0, staticDly[c*smc_pkg::DLY_W +: smc_pkg::DLY_W]}
			+ (srSelect[c] ? {1'b0, srDly[c*smc_pkg::DLY_W +: smc_pkg::DLY_W]}
			: '0);
		assign held = powerDown | syncHold | (dlyCnt_r != '0);
		assign cdTick = (cdCnt_r + 12'h001 >= cdLim);
		// divider ratio of at least one keeps the output at or below src/2
		assign srTick[c] = cdTick & (srCnt_r + 20'h00001 >= srLim);
		// equal delays released on the same edge start in phase
		always_ff @(posedge sys_clk) begin
			if (sys_rst || powerDown || syncHold) begin
				dlyCnt_r <= dlyLoad;
			end else if (startOk && dlyCnt_r != '0) begin
				dlyCnt_r <= dlyCnt_r - 9'h001;
			end
		end
		always_ff @(posedge sys_clk) begin
			if (sys_rst || held) begin
				cdCnt_r <= '0;
				srCnt_r <= '0;
				cdOut_r <= 1'b0;
				srOut_r <= 1'b0;
			end else begin
				cdCnt_r <= cdTick ? '0 : cdCnt_r + 12'h001;
				if (cdTick) begin
					cdOut_r <= ~cdOut_r;
					srCnt_r <= srTick[c] ? '0 : srCnt_r + 20'h00001;
				end
				if (srTick[c]) begin
					srOut_r <= ~srOut_r;
				end
			end
		end
		// continuous replica taken before analog delay and pulser
		assign replTap[c] = srOut_r & srSelect[c]
			& divider_pin_replica_enable[c] & ~held;
		assign base = srSelect[c] ? srOut_r : cdOut_r;
		always_ff @(posedge sys_clk) begin
			if (sys_rst || held) begin
				adly_r <= 1'b0;
			end else begin
				adly_r <= base;
			end
		end
		assign shaped = (srSelect[c] && analogDlyEn[c]) ? adly_r : base;

		// burst of pulses per request in pulsed mode
		always_ff @(posedge sys_clk) begin
			if (sys_rst || held) begin
				pState_r <= smc_pkg::SMC_PULSE_IDLE;
				pulseCnt_r <= '0;
			end else begin
				case (pState_r)
					smc_pkg::SMC_PULSE_IDLE: begin
						if (reqFire) begin
							pState_r <= smc_pkg::SMC_PULSE_BURST;
							pulseCnt_r <= smc_pkg::PULSE_CNT;
						end
					end
					smc_pkg::SMC_PULSE_BURST: begin
						if (srTick[c] && srOut_r) begin
							pulseCnt_r <= pulseCnt_r - 4'h1;
							if (pulseCnt_r == 4'h1) begin
								pState_r <= smc_pkg::SMC_PULSE_IDLE;
							end
						end
					end
					default: pState_r <= smc_pkg::SMC_PULSE_IDLE;
				endcase
			end
		end

		// gate and mute change only while the path is low: no runt pulses
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				gateOpen_r <= 1'b0;
				muted_r <= 1'b0;
			end else if (!shaped) begin
				gateOpen_r <= ~(srSelect[c] & pulsedMode[c])
					| (pState_r == smc_pkg::SMC_PULSE_BURST);
				muted_r <= muteCond;
			end
		end

		always_ff @(posedge sys_clk) begin
			if (sys_rst || held) begin
				chOut[c] <= 1'b0;
			end else begin
				chOut[c] <= shaped & gateOpen_r & ~muted_r;
			end
		end

		assign divPowered[c] = ~powerDown;
	end

	// ============================================================
	// auxiliary pin replicas and single-ended drivers
	for (genvar p = 0; p < smc_pkg::NAUX; p++) begin : g_aux
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				auxOut[p] <= 1'b0;
				auxOe[p] <= 1'b0;
			end else begin
				auxOe[p] <= aux_pin_output_enable[p];
				auxOut[p] <= aux_pin_output_enable[p] & |replTap;
			end
		end
	end

	// pins 0,1 follow channel 0 and pins 2,3 follow channel 1
	for (genvar k = 0; k < smc_pkg::NCMOS; k++) begin : g_cmos
		logic [1:0] drv;
		assign drv = cmos_drive(cmosMode[k*2 +: 2], chOut[k/2]);
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				cmosOut[k] <= 1'b0;
				cmosOe[k] <= 1'b0;
			end else begin
				cmosOut[k] <= drv[0];
				cmosOe[k] <= drv[1];
			end
		end
	end

endmodule : smc_output_ctrl

// file: smc_chk.sv
`timescale 1ns/100ps
// ============================================================
// port checks for the output mute block
module smc_chk (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic regWrEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic analogLossOfLock,
	input wire logic syncPin,
	input wire logic [3:0] syncEn,
	input wire logic [7:0] driverEn,
	input wire logic [3:0] muteEn,
	input wire logic [3:0] mute_on_analog_loop_unlock,
	input wire logic [3:0] divider_pin_replica_enable,
	input wire logic [1:0] aux_pin_output_enable,
	input wire logic [7:0] cmosMode,
	input wire logic [3:0] chOut,
	input wire logic [3:0] divPowered,
	input wire logic [1:0] auxOut,
	input wire logic [3:0] cmosOe,
	input wire logic [3:0] cmosOut
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_wr;
		regWrEn && regAddr == 8'h1a;
	endsequence
	sequence s_rd;
		!regWrEn && regAddr == 8'h1a;
	endsequence
	wire logic mute0;
	assign mute0 = analogLossOfLock && muteEn[0] && mute_on_analog_loop_unlock[0];
	a_reg_readback: assert property (
		s_wr ##1 s_rd |=> regRdData == $past(regWrData, 2))
		else $error("control readback differs");
	a_rd_unmapped: assert property (
		regAddr != 8'h1a |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	a_pd_follow: assert property (divPowered == {|driverEn[7:6],
		|driverEn[5:4], |driverEn[3:2], |driverEn[1:0]})
		else $error("divider power wrong");
	a_pd_quiet: assert property (
		(!divPowered[0])[*3] |-> !chOut[0])
		else $error("powered down output toggles");
	a_sync_low: assert property (
		(syncPin && syncEn[0])[*8] |-> !chOut[0])
		else $error("output high during sync");
	a_mute_norise: assert property (
		mute0[*8] ##1 mute0 |-> !$rose(chOut[0]))
		else $error("muted output rose");
	a_hiz_off: assert property (
		!$past(sys_rst) && $past(cmosMode[1:0]) == 2'h2 |-> !cmosOe[0])
		else $error("hi-z pin driven");
	a_low_static: assert property (
		!$past(sys_rst) && $past(cmosMode[1:0]) == 2'h3
		|-> cmosOe[0] && !cmosOut[0])
		else $error("static low pin wrong");
	a_aux_gate: assert property (
		!$past(sys_rst) && !$past(aux_pin_output_enable[0]) |-> !auxOut[0])
		else $error("aux out while disabled");
	a_aux_nosrc: assert property (
		!$past(sys_rst) && $past(divider_pin_replica_enable) == 4'h0
		|-> auxOut == 2'h0)
		else $error("aux out without source");
endmodule : smc_chk
bind smc_output_ctrl smc_chk u_chk (.*);

// file: smc_rx_model.sv
`timescale 1ns/100ps
// ============================================================
// downstream receiver: counts rising edges, times the last period
module smc_rx_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkIn,
	output int edges,
	output int period
);
	logic last_r;
	int gap_r;
	always_ff @(posedge sys_clk) begin
		last_r <= clkIn;
		if (sys_rst) begin
			edges <= 0;
			gap_r <= 0;
		end else if (clkIn && !last_r) begin
			edges <= edges + 1;
			period <= gap_r;
			gap_r <= 1;
		end else begin
			gap_r <= gap_r + 1;
		end
	end
endmodule : smc_rx_model

// file: sysref_output_mute_control_bench.sv
`timescale 1ns/100ps
module sysref_output_mute_control_bench;
	logic sys_clk = 0, sys_rst = 1, regWrEn = 0, syncPin = 0, sysrefReq = 0;
	logic analogLossOfLock = 0, digitalLossOfLock = 0, phaseLossOfLock = 0;
	logic [7:0] regAddr = 0, regWrData = 0, driverEn = 8'hff, cmosMode = 0;
	logic [7:0] regRdData;
	logic [47:0] chDiv = 0;
	logic [79:0] srDiv = 0;
	logic [31:0] staticDly = 0, srDly = 0;
	logic [3:0] srSelect = 0, analogDlyEn = 0, pulsedMode = 0, syncEn = 4'hf;
	logic [3:0] muteEn = 0, mute_on_analog_loop_unlock = 0;
	logic [3:0] mute_on_digital_loop_unlock = 0;
	logic [3:0] mute_on_digital_phase_unlock = 0;
	logic [3:0] divider_pin_replica_enable = 0, chOut, divPowered;
	logic [3:0] cmosOut, cmosOe;
	logic [1:0] aux_pin_output_enable = 0, auxOut, auxOe;
	int errors = 0, n_checks = 0, chE, chP, axE, axP;
	int q[$];
	smc_output_ctrl u_dut (.*);
	smc_rx_model u_rxc (.sys_clk, .sys_rst, .clkIn(chOut[0]), .edges(chE),
		.period(chP));
	smc_rx_model u_rxa (.sys_clk, .sys_rst, .clkIn(auxOut[0]), .edges(axE),
		.period(axP));
	always #20 sys_clk = ~sys_clk;
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic regWr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWrEn <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrEn <= 0;
	endtask : regWr
	task automatic regRd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		cyc(2);
		#1 d = regRdData;
	endtask : regRd
	// bounded: a dead divider must end the run, not hang it
	task automatic waitEdges(input int n, input bit aux);
		int t;
		t = (aux ? axE : chE) + n;
		for (int i = 0; i < 4000 && (aux ? axE : chE) < t; i++) cyc(1);
		if ((aux ? axE : chE) < t) begin
			errors++;
			wrap_up();
		end
	endtask : waitEdges
	initial begin
		logic [7:0] d, x;
		int cd, sd, per, e0, eb;
		void'($urandom(32'h6afc));
		@(posedge sys_clk);
		staticDly <= $urandom;
		srDly <= $urandom;
		cyc(7);
		sys_rst <= 0;
		// ============================================================
		// control register
		regRd(8'h1a, d);
		chk(d, 8'h00);
		x = {2'($urandom), 2'h3, 2'h0, 2'($urandom)};
		regWr(8'h1a, x);
		regRd(8'h1a, d);
		chk(d, x);
		regWr(8'h5c, 8'hff);
		regRd(8'h5c, d);
		chk(d, 8'h00);
		$display("registers done");
		// ============================================================
		// divider paths, plain and cascaded
		for (int k = 0; k < 4; k++) begin
			cd = $urandom_range(1, 4);
			sd = $urandom_range(1, 3);
			@(posedge sys_clk);
			chDiv[11:0] <= 12'(cd);
			srDiv[19:0] <= 20'(sd);
			srSelect[0] <= k[1];
			analogDlyEn[0] <= k[0];
			q.push_back(2 * cd * (k[1] ? sd : 1));
			waitEdges(4, 0);
			per = q.pop_front();
			chk(chP, per);
		end
		$display("dividers done");
		// ============================================================
		// mute per loop source, relock, then mute disabled
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			muteEn[0] <= 1;
			{mute_on_digital_phase_unlock[0], mute_on_digital_loop_unlock[0],
				mute_on_analog_loop_unlock[0]} <= 3'h1 << k;
			{phaseLossOfLock, digitalLossOfLock, analogLossOfLock} <= 3'h7;
			cyc(4 * per + 12);
			e0 = chE;
			cyc(40);
			chk(chE - e0, 0);
			{phaseLossOfLock, digitalLossOfLock, analogLossOfLock} <= 3'h0;
			waitEdges(3, 0);
			chk(chP, per);
			muteEn[0] <= 0;
			{phaseLossOfLock, digitalLossOfLock, analogLossOfLock} <= 3'h7;
			waitEdges(3, 0);
			chk(chP, per);
			{phaseLossOfLock, digitalLossOfLock, analogLossOfLock} <= 3'h0;
		end
		$display("mute done");
		// ============================================================
		// sync hold and release
		syncPin <= 1;
		cyc(12);
		e0 = chE;
		cyc(30);
		chk(chE - e0, 0);
		syncPin <= 0;
		waitEdges(3, 0);
		chk(chP, per);
		for (int j = 0; j < 4; j++) begin
			driverEn[1:0] <= 2'(j);
			cyc(3);
			#1 chk(divPowered, {3'h7, j != 0});
			cyc(1);
		end
		$display("sync and power done");
		// ============================================================
		// single-ended pins, pin zero stepped through all four modes, pin one inverted
		for (int m = 0; m < 4; m++) begin
			cmosMode <= {4'h0, 2'h1, 2'(m)};
			cyc(2);
			#1 chk(cmosOe[1:0], {1'b1, m != 2});
			if (m == 3) chk(cmosOut[0], 0);
			if (m < 2) chk(cmosOut[0] ^ cmosOut[1], m == 0);
			cyc(1);
		end
		$display("pins done");
		// ============================================================
		// aux replica stays continuous though the channel is pulsed
		aux_pin_output_enable <= 2'h1;
		divider_pin_replica_enable <= 4'h1;
		pulsedMode[0] <= 1;
		waitEdges(3, 1);
		chk(axP, per);
		chk(auxOe, 2'h1);
		// let the channel gate close before counting the burst
		cyc(per + 4);
		eb = chE;
		sysrefReq <= 1;
		divider_pin_replica_enable <= 4'h0;
		cyc(4 * per + 4);
		e0 = axE;
		cyc(40);
		chk(axE - e0, 0);
		chk(chE - eb, 32'(smc_pkg::PULSE_CNT));
		divider_pin_replica_enable <= 4'h1;
		aux_pin_output_enable <= 2'h0;
		sysrefReq <= 0;
		cyc(3);
		#1 chk(auxOut, 0);
		chk(auxOe, 2'h0);
		$display("aux done");
		wrap_up();
	end
endmodule : sysref_output_mute_control_bench
